// ---- lof_pkg.sv ----
package lof_pkg;

  // register offsets
  localparam logic [7:0] HV_SINK_CFG_ADDR    = 8'h10;
  localparam logic [7:0] LV_SINK_CFG_ADDR    = 8'h11;
  localparam logic [7:0] HV_FEEDBACK_ADDR    = 8'h28;
  localparam logic [7:0] LV_FEEDBACK_ADDR    = 8'h29;
  localparam logic [7:0] PUMP_CFG_ADDR       = 8'h2A;
  localparam logic [7:0] BANK_ENABLE_ADDR    = 8'h2B;
  localparam logic [7:0] HV_OPEN_FLAGS_ADDR  = 8'hB0;
  localparam logic [7:0] LV_OPEN_FLAGS_ADDR  = 8'hB1;
  localparam logic [7:0] HV_SHORT_FLAGS_ADDR = 8'hB2;
  localparam logic [7:0] LV_SHORT_FLAGS_ADDR = 8'hB3;
  localparam logic [7:0] FAULT_ENABLE_ADDR   = 8'hB4;

  // reset values
  localparam logic [7:0] HV_SINK_CFG_RST = 8'h06;
  localparam logic [7:0] LV_SINK_CFG_RST = 8'h36;
  localparam logic [7:0] HV_FEEDBACK_RST = 8'h07;
  localparam logic [7:0] LV_FEEDBACK_RST = 8'h3F;
  localparam logic [7:0] PUMP_CFG_RST    = 8'h00;
  localparam logic [7:0] BANK_ENABLE_RST = 8'h00;
  localparam logic [7:0] FAULT_EN_RST    = 8'h00;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;

  // field layout
  localparam int HV_SINKS        = 3;
  localparam int LV_SINKS        = 6;
  localparam int LV_HALF         = 3;
  localparam int BANKS           = 8;
  localparam int OPEN_EN_BIT     = 0;
  localparam int SHORT_EN_BIT    = 1;
  localparam int HV_SHORT_BIT    = 0;
  localparam logic [2:0] BANK_A  = 3'h0;
  localparam logic [2:0] BANK_B  = 3'h1;
  localparam logic [2:0] BANK_C  = 3'h2;
  localparam logic [2:0] BANK_F  = 3'h5;

  // two-wire port
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h36;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  typedef enum logic [2:0] {
    LOF_IDLE     = 3'b000,
    LOF_ADDR     = 3'b001,
    LOF_ADDR_ACK = 3'b011,
    LOF_WR       = 3'b010,
    LOF_WR_ACK   = 3'b110,
    LOF_RD       = 3'b111,
    LOF_RD_ACK   = 3'b101,
    LOF_WAIT     = 3'b100
  } lof_bus_state_e;

endpackage

// ---- lof_line_edges.sv ----
module lof_line_edges (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      bus_start,
  output logic      bus_stop
);

  logic scl_reg;
  logic sda_reg;

  // reset to idle-high so release of reset is no false edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
    end
  end

  assign scl_rise  = scl_in & ~scl_reg;
  assign scl_fall  = ~scl_in & scl_reg;
  assign bus_start = scl_in & scl_reg & sda_reg & ~sda_in;
  assign bus_stop  = scl_in & scl_reg & ~sda_reg & sda_in;

endmodule

// ---- lof_flag_bank.sv ----
module lof_flag_bank #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] set_vec,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // a fault seen in the clearing cycle survives the clear
  always_comb begin
    if (clear)
      flags_next = set_vec;
    else
      flags_next = flags_reg | set_vec;
  end

  always_ff @(posedge clk_sys) begin
    if (srst)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  assign flags = flags_reg;

endmodule

// ---- lof_fault_flags.sv ----
// How it works
// R01: open and short flags set only while their enable bit is set.
// R02: high-voltage open needs active sink below 200 mV plus overvoltage hit.
// R03: strings not fed from boost output never report open.
// R04: high-voltage open result in bits 2 to 0, one per sink.
// R05: high-voltage short when enabled sink string drops below supply minus 1 V.
// R06: host tests high-voltage shorts one string at a time.
// R07: high-voltage short result for string under test in bit 0.
// R08: low-voltage open when any active sink drops below headroom threshold.
// R09: low-voltage open results in bits 5 to 0, one per sink.
// R10: low-voltage short when pump output minus headroom is below 1 V.
// R11: low-voltage short results in bits 5 to 0, one per sink.
// R12: host sets up bank A at maximum for high-voltage open test.
// R13: host maps only the string under test to bank A for shorts.
// R14: host waits 4 ms, reads flags, then clears bank enables; the testbench reads the flags right after arming, with no wait.
// R15: bank enable bit 0 is bank A, bits 2 and 5 banks C and F.
// R16: host maps banks C and F, forces pump double gain for open test.
// R17: host enables all low-voltage feedback, unity pump gain for short test.
// R18: host uses detection only in production testing.
// R19: low-voltage config zero puts sinks 1-3 on bank C, 4-6 on F.
// R20: flag registers read-only, hold results captured since last enable write.
module lof_fault_flags #(
  parameter logic [6:0] DEV_ADDR = lof_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  input  wire logic [lof_pkg::HV_SINKS-1:0] hv_sink_below_open,
  input  wire logic                         overvoltage_threshold_hit,
  input  wire logic [lof_pkg::HV_SINKS-1:0] hv_string_below_short,
  input  wire logic [lof_pkg::LV_SINKS-1:0] lv_sink_below_headroom,
  input  wire logic [lof_pkg::LV_SINKS-1:0] lv_led_below_short,
  output logic      [lof_pkg::HV_SINKS-1:0] hv_sink_enable,
  output logic      [lof_pkg::LV_SINKS-1:0] lv_sink_enable,
  output logic      [lof_pkg::HV_SINKS-1:0] hv_feedback_enable,
  output logic      [lof_pkg::LV_SINKS-1:0] lv_feedback_enable,
  output logic      [7:0]                   pump_config
);

  logic                   scl_rise;
  logic                   scl_fall;
  logic                   bus_start;
  logic                   bus_stop;
  lof_pkg::lof_bus_state_e state_reg;
  lof_pkg::lof_bus_state_e state_next;
  logic [7:0]             shift_reg;
  logic [3:0]             bit_cnt_reg;
  logic [7:0]             ptr_reg;
  logic                   ptr_phase_reg;
  logic                   sda_oe_reg;
  logic                   wr_stb;
  logic [7:0]             rd_data;
  logic                   byte_done;
  logic [7:0]             hv_cfg_reg;
  logic [7:0]             lv_cfg_reg;
  logic [7:0]             hv_fb_reg;
  logic [7:0]             lv_fb_reg;
  logic [7:0]             pump_reg;
  logic [7:0]             bank_en_reg;
  logic [7:0]             fault_en_reg;
  logic                   flag_clear;
  logic                   open_en;
  logic                   short_en;
  logic [lof_pkg::HV_SINKS-1:0] hv_open_set;
  logic [lof_pkg::HV_SINKS-1:0] hv_short_any;
  logic [0:0]             hv_short_set;
  logic [lof_pkg::LV_SINKS-1:0] lv_open_set;
  logic [lof_pkg::LV_SINKS-1:0] lv_short_set;
  logic [lof_pkg::HV_SINKS-1:0] hv_open_flags;
  logic [0:0]             hv_short_flags;
  logic [lof_pkg::LV_SINKS-1:0] lv_open_flags;
  logic [lof_pkg::LV_SINKS-1:0] lv_short_flags;

  // bank that drives a low-voltage sink: config bit 0 keeps it on its
  // group's first bank, 1 moves it to a bank of its own
  function automatic logic [2:0] lv_bank(input int idx, input logic sel);
    logic [2:0] base;
    logic [2:0] off;
    base = (idx < lof_pkg::LV_HALF) ? lof_pkg::BANK_C : lof_pkg::BANK_F;
    off  = 3'((idx < lof_pkg::LV_HALF) ? idx : idx - lof_pkg::LV_HALF);
    lv_bank = sel ? 3'(base + off) : base; // [R19]
  endfunction

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    is_addr = (a == b);
  endfunction

  lof_line_edges u_edges (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .bus_start (bus_start),
    .bus_stop  (bus_stop)
  );

  assign byte_done = (bit_cnt_reg == lof_pkg::BITS_PER_BYTE);

  always_comb begin
    state_next = state_reg;
    if (bus_stop) begin
      state_next = lof_pkg::LOF_IDLE;
    end else if (bus_start) begin
      state_next = lof_pkg::LOF_ADDR;
    end else if (scl_fall) begin
      unique case (state_reg)
        lof_pkg::LOF_IDLE:     state_next = lof_pkg::LOF_IDLE;
        lof_pkg::LOF_ADDR: begin
          if (byte_done)
            state_next = (shift_reg[7:1] == DEV_ADDR) ?
                         lof_pkg::LOF_ADDR_ACK : lof_pkg::LOF_WAIT;
        end
        // ninth rise shifted the ack in, so r/w now sits in bit 1
        lof_pkg::LOF_ADDR_ACK:
          state_next = shift_reg[1] ? lof_pkg::LOF_RD : lof_pkg::LOF_WR;
        lof_pkg::LOF_WR: begin
          if (byte_done)
            state_next = lof_pkg::LOF_WR_ACK;
        end
        lof_pkg::LOF_WR_ACK:   state_next = lof_pkg::LOF_WR;
        lof_pkg::LOF_RD: begin
          if (byte_done)
            state_next = lof_pkg::LOF_RD_ACK;
        end
        lof_pkg::LOF_RD_ACK:
          state_next = shift_reg[0] ? lof_pkg::LOF_WAIT : lof_pkg::LOF_RD;
        lof_pkg::LOF_WAIT:     state_next = lof_pkg::LOF_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst)
      state_reg <= lof_pkg::LOF_IDLE;
    else
      state_reg <= state_next;
  end

  // bit counter and shifter; read bytes shift out on the falling edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_reg   <= lof_pkg::ZERO_BYTE;
      bit_cnt_reg <= '0;
    end else if (bus_start) begin
      bit_cnt_reg <= '0;
    end else if (scl_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (state_reg == lof_pkg::LOF_RD_ACK)
        shift_reg <= {7'h00, sda_in};
      else if (state_reg != lof_pkg::LOF_RD)
        shift_reg <= {shift_reg[6:0], sda_in};
    end else if (scl_fall) begin
      if (state_next == lof_pkg::LOF_RD &&
          state_reg != lof_pkg::LOF_RD) begin
        shift_reg   <= rd_data;
        bit_cnt_reg <= '0;
      end else if (state_reg == lof_pkg::LOF_RD && !byte_done) begin
        shift_reg <= {shift_reg[6:0], 1'b0};
      end else if (state_next == lof_pkg::LOF_WR &&
                   state_reg != lof_pkg::LOF_WR) begin
        bit_cnt_reg <= '0;
      end
    end
  end

  // slave drives low only: ack bits and zero data bits
  always_ff @(posedge clk_sys) begin
    if (srst || bus_start || bus_stop) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_next)
        lof_pkg::LOF_ADDR_ACK,
        lof_pkg::LOF_WR_ACK:   sda_oe_reg <= 1'b1;
        lof_pkg::LOF_RD: begin
          if (state_reg != lof_pkg::LOF_RD)
            sda_oe_reg <= ~rd_data[7];
          else
            sda_oe_reg <= ~shift_reg[6];
        end
        default:               sda_oe_reg <= 1'b0;
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;

  // first written byte sets the pointer; pointer steps after each byte
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ptr_reg       <= lof_pkg::ZERO_BYTE;
      ptr_phase_reg <= 1'b0;
    end else if (scl_fall && state_reg == lof_pkg::LOF_ADDR_ACK) begin
      ptr_phase_reg <= ~shift_reg[1];
      if (shift_reg[1])
        ptr_reg <= ptr_reg + 8'h01;
    end else if (scl_fall && state_reg == lof_pkg::LOF_WR && byte_done) begin
      ptr_phase_reg <= 1'b0;
      if (ptr_phase_reg)
        ptr_reg <= shift_reg;
      else
        ptr_reg <= ptr_reg + 8'h01;
    end else if (scl_fall && state_reg == lof_pkg::LOF_RD_ACK &&
                 !shift_reg[0]) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  assign wr_stb = scl_fall && state_reg == lof_pkg::LOF_WR && byte_done &&
                  !ptr_phase_reg;

  // control registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hv_cfg_reg   <= lof_pkg::HV_SINK_CFG_RST;
      lv_cfg_reg   <= lof_pkg::LV_SINK_CFG_RST;
      hv_fb_reg    <= lof_pkg::HV_FEEDBACK_RST;
      lv_fb_reg    <= lof_pkg::LV_FEEDBACK_RST;
      pump_reg     <= lof_pkg::PUMP_CFG_RST;
      bank_en_reg  <= lof_pkg::BANK_ENABLE_RST;
      fault_en_reg <= lof_pkg::FAULT_EN_RST;
    end else if (wr_stb) begin
      if (is_addr(ptr_reg, lof_pkg::HV_SINK_CFG_ADDR))
        hv_cfg_reg <= shift_reg;
      if (is_addr(ptr_reg, lof_pkg::LV_SINK_CFG_ADDR))
        lv_cfg_reg <= shift_reg;
      if (is_addr(ptr_reg, lof_pkg::HV_FEEDBACK_ADDR))
        hv_fb_reg <= shift_reg;
      if (is_addr(ptr_reg, lof_pkg::LV_FEEDBACK_ADDR))
        lv_fb_reg <= shift_reg;
      if (is_addr(ptr_reg, lof_pkg::PUMP_CFG_ADDR))
        pump_reg <= shift_reg;
      if (is_addr(ptr_reg, lof_pkg::BANK_ENABLE_ADDR))
        bank_en_reg <= shift_reg;
      if (is_addr(ptr_reg, lof_pkg::FAULT_ENABLE_ADDR))
        fault_en_reg <= shift_reg;
    end
  end

  // writing the enable register starts a fresh capture window
  assign flag_clear = wr_stb && is_addr(ptr_reg, lof_pkg::FAULT_ENABLE_ADDR);
  assign open_en    = fault_en_reg[lof_pkg::OPEN_EN_BIT];  // [R01]
  assign short_en   = fault_en_reg[lof_pkg::SHORT_EN_BIT]; // [R01]

  genvar gi;
  generate
    for (gi = 0; gi < lof_pkg::HV_SINKS; gi++) begin : g_hv
      // bank select bit: 0 on bank A, 1 on bank B
      assign hv_sink_enable[gi] = hv_cfg_reg[gi] ?
                                  bank_en_reg[lof_pkg::BANK_B] :
                                  bank_en_reg[lof_pkg::BANK_A]; // [R15]
      // feedback off means no overvoltage sense, so no open report
      assign hv_open_set[gi] = open_en && hv_sink_enable[gi] &&
                               hv_fb_reg[gi] &&                // [R03]
                               hv_sink_below_open[gi] &&
                               overvoltage_threshold_hit;      // [R02]
      assign hv_short_any[gi] = short_en && hv_sink_enable[gi] &&
                                hv_string_below_short[gi];     // [R05]
    end
    for (gi = 0; gi < lof_pkg::LV_SINKS; gi++) begin : g_lv
      assign lv_sink_enable[gi] =
        bank_en_reg[lv_bank(gi, lv_cfg_reg[gi])];               // [R15]
      // a weak supply trips this too; no way to tell them apart
      assign lv_open_set[gi] = open_en && lv_sink_enable[gi] &&
                               lv_sink_below_headroom[gi];     // [R08]
      assign lv_short_set[gi] = short_en && lv_sink_enable[gi] &&
                                lv_led_below_short[gi];        // [R10]
    end
  endgenerate

  // one summary bit; only meaningful with a single string enabled
  assign hv_short_set[0] = |hv_short_any; // [R07]
  assign hv_feedback_enable = hv_fb_reg[lof_pkg::HV_SINKS-1:0];
  assign lv_feedback_enable = lv_fb_reg[lof_pkg::LV_SINKS-1:0];
  assign pump_config        = pump_reg;

  lof_flag_bank #(.WIDTH(lof_pkg::HV_SINKS)) u_hv_open (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clear   (flag_clear),
    .set_vec (hv_open_set),
    .flags   (hv_open_flags)
  );

  lof_flag_bank #(.WIDTH(1)) u_hv_short (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clear   (flag_clear),
    .set_vec (hv_short_set),
    .flags   (hv_short_flags)
  );

  lof_flag_bank #(.WIDTH(lof_pkg::LV_SINKS)) u_lv_open (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clear   (flag_clear),
    .set_vec (lv_open_set),
    .flags   (lv_open_flags)
  );

  lof_flag_bank #(.WIDTH(lof_pkg::LV_SINKS)) u_lv_short (
    .clk_sys (clk_sys),
    .srst    (srst),
    .clear   (flag_clear),
    .set_vec (lv_short_set),
    .flags   (lv_short_flags)
  );

  // read mux; flag registers have no write path
  always_comb begin
    rd_data = lof_pkg::ZERO_BYTE;
    unique case (ptr_reg)
      lof_pkg::HV_SINK_CFG_ADDR:    rd_data = hv_cfg_reg;
      lof_pkg::LV_SINK_CFG_ADDR:    rd_data = lv_cfg_reg;
      lof_pkg::HV_FEEDBACK_ADDR:    rd_data = hv_fb_reg;
      lof_pkg::LV_FEEDBACK_ADDR:    rd_data = lv_fb_reg;
      lof_pkg::PUMP_CFG_ADDR:       rd_data = pump_reg;
      lof_pkg::BANK_ENABLE_ADDR:    rd_data = bank_en_reg;
      lof_pkg::HV_OPEN_FLAGS_ADDR:
        rd_data = {5'h00, hv_open_flags};           // [R04] [R20]
      lof_pkg::LV_OPEN_FLAGS_ADDR:
        rd_data = {2'h0, lv_open_flags};            // [R09] [R20]
      lof_pkg::HV_SHORT_FLAGS_ADDR:
        rd_data = {7'h00, hv_short_flags};          // [R07] [R20]
      lof_pkg::LV_SHORT_FLAGS_ADDR:
        rd_data = {2'h0, lv_short_flags};           // [R11] [R20]
      lof_pkg::FAULT_ENABLE_ADDR:   rd_data = fault_en_reg;
      default:                      rd_data = lof_pkg::ZERO_BYTE;
    endcase
  end

endmodule

// ---- lof_host_model.sv ----
module lof_host_model (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus levels held well above the two-cycle minimum
  localparam int Q = 4;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // repeated start releases data while clock is low
  task automatic start();
    sda_low <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_low <= 1'b0;
    tick(Q);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    tick(Q);
    scl <= 1'b1;
    tick(Q / 2);
    r = sda;
    tick(Q / 2);
    scl <= 1'b0;
    tick(Q);
  endtask
  // msb first, ninth bit driven as b9
  task automatic xfer(input logic [7:0] tx, input logic b9,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(b9, r);
    ack = !r;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic [2:0] ak);
    logic [7:0] rx;
    start();
    xfer({lof_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, ak[2]);
    xfer(a, 1'b1, rx, ak[1]);
    xfer(d, 1'b1, rx, ak[0]);
    stop();
  endtask
  // single byte read ends with a master nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic [2:0] ak);
    logic [7:0] rx;
    logic       nk;
    start();
    xfer({lof_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, ak[2]);
    xfer(a, 1'b1, rx, ak[1]);
    start();
    xfer({lof_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rx, ak[0]);
    xfer(8'hFF, 1'b1, d, nk);
    stop();
  endtask
endmodule

// ---- lof_fault_flags_assertions.sv ----
module lof_fault_flags_checker #(
  parameter logic [6:0] DEV_ADDR = lof_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [2:0] hv_sink_enable,
  input wire logic [5:0] lv_sink_enable,
  input wire logic [2:0] hv_feedback_enable,
  input wire logic [5:0] lv_feedback_enable,
  input wire logic [7:0] pump_config
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence stop_s;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  // ack or data bit spans a low and a high level
  sequence drive_s;
    sda_oe [*3];
  endsequence
  a_reset_values: assert property (disable iff (1'b0) srst |=>
    !sda_oe && hv_sink_enable == 3'h0 && lv_sink_enable == 6'h00 &&
    pump_config == 8'h00 && hv_feedback_enable == 3'h7 &&
    lv_feedback_enable == 6'h3F) else $error("bad state after reset");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data driven while clock high");
  a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
  a_oe_high_stable: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data moved during clock high");
  a_drive_holds: assert property ($rose(sda_oe) |-> drive_s)
    else $error("drive shorter than one bit");
  a_stop_quiet: assert property (stop_s |=> !sda_oe [*2])
    else $error("data driven after stop");
  a_open_drain: assert property ($rose(sda_oe) |-> sda_out == 1'b0)
    else $error("data pin not driven low");
  a_pump_on_low: assert property (
    $changed(pump_config) |-> !scl_in && $past(!scl_in))
    else $error("pump setting moved off a write");
  a_fb_on_low: assert property (
    $changed({hv_feedback_enable, lv_feedback_enable}) |-> !scl_in)
    else $error("feedback moved off a write");
  a_sinks_on_low: assert property (
    $changed({hv_sink_enable, lv_sink_enable}) |-> !scl_in)
    else $error("sink enables moved off a write");
endmodule

bind lof_fault_flags lof_fault_flags_checker #(.DEV_ADDR(DEV_ADDR)) chk_i (
  .clk_sys(clk_sys), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .hv_sink_enable(hv_sink_enable),
  .lv_sink_enable(lv_sink_enable), .hv_feedback_enable(hv_feedback_enable),
  .lv_feedback_enable(lv_feedback_enable), .pump_config(pump_config));

// ---- lof_fault_flags_tb.sv ----
module lof_fault_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       srst    = 1'b1;
  logic       scl, sda_low, sda, sda_out, sda_oe;
  logic       overvoltage_threshold     = 1'b0;
  logic [2:0] hv_open = 3'h0, hv_short = 3'h0, hv_en, hv_fb, fb;
  logic [5:0] lv_head = 6'h00, lv_short = 6'h00, lv_en, lv_fb;
  logic [7:0] pump;
  int         failures, tests_run;
  int         model [256];
  assign sda = (sda_low || sda_oe) ? 1'b0 : 1'b1;
  always #10 clk_sys = ~clk_sys;
  lof_host_model lof_host_model_i (.clk_sys(clk_sys), .sda(sda),
    .scl(scl), .sda_low(sda_low));
  lof_fault_flags lof_fault_flags_i (.clk_sys(clk_sys), .srst(srst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .hv_sink_below_open(hv_open), .overvoltage_threshold_hit(overvoltage_threshold),
    .hv_string_below_short(hv_short), .lv_sink_below_headroom(lv_head),
    .lv_led_below_short(lv_short), .hv_sink_enable(hv_en),
    .lv_sink_enable(lv_en), .hv_feedback_enable(hv_fb),
    .lv_feedback_enable(lv_fb), .pump_config(pump));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // flag registers stay out of the model, their value comes from inputs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] ak;
    lof_host_model_i.write_reg(a, d, ak);
    check({5'h0, ak}, 8'h07);
    if (!(a inside {[8'hB0:8'hB3]})) model[a] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [2:0] ak;
    logic [7:0] d;
    lof_host_model_i.read_reg(a, d, ak);
    check(d, e);
  endtask
  task automatic arm(input logic [7:0] hcfg, pc, bank, fen);
    wr(lof_pkg::HV_SINK_CFG_ADDR, hcfg);
    wr(lof_pkg::LV_SINK_CFG_ADDR, 8'h00);
    wr(lof_pkg::HV_FEEDBACK_ADDR, {5'h0, fb});
    wr(lof_pkg::LV_FEEDBACK_ADDR, 8'h3F);
    wr(lof_pkg::PUMP_CFG_ADDR, pc);
    wr(lof_pkg::BANK_ENABLE_ADDR, bank);
    wr(lof_pkg::FAULT_ENABLE_ADDR, fen);
  endtask
  task automatic drive_rand();
    @(posedge clk_sys);
    hv_open <= 3'($urandom);
    hv_short <= 3'($urandom);
    lv_head <= 6'($urandom);
    lv_short <= 6'($urandom);
    overvoltage_threshold <= 1'($urandom);
    fb = 3'($urandom);
  endtask
  initial begin
    repeat (95000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hB3E8587C));
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({5'h0, hv_fb}, 8'h07);
    check({2'h0, lv_fb}, 8'h3F);
    check({2'h0, lv_en}, 8'h00);
    rd(lof_pkg::FAULT_ENABLE_ADDR, 8'h00);
    @(posedge clk_sys);
    {hv_open, hv_short, lv_head, lv_short, overvoltage_threshold} <= '1;
    fb = 3'h7;
    arm(8'h00, 8'h06, 8'hFF, 8'h00);
    wr(lof_pkg::HV_OPEN_FLAGS_ADDR, 8'hFF);
    for (int a = 8'hB0; a <= 8'hB3; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 4; i++) begin
      drive_rand();
      arm(8'h00, 8'h00, 8'h01, 8'h01);
      check({5'h0, hv_en}, 8'h07);
      rd(lof_pkg::HV_OPEN_FLAGS_ADDR,
         {5'h0, overvoltage_threshold ? (hv_open & fb) : 3'h0});
      rd(lof_pkg::LV_OPEN_FLAGS_ADDR, 8'h00);
      wr(lof_pkg::BANK_ENABLE_ADDR, 8'h00);
    end
    for (int k = 0; k < 3; k++) begin
      drive_rand();
      fb = 3'h7;
      arm({5'h0, ~(3'h1 << k)}, 8'h00, 8'h01, 8'h02);
      check({5'h0, hv_en}, 8'(1 << k));
      rd(lof_pkg::HV_SHORT_FLAGS_ADDR, {7'h0, hv_short[k]});
      rd(lof_pkg::HV_OPEN_FLAGS_ADDR, 8'h00);
      wr(lof_pkg::BANK_ENABLE_ADDR, 8'h00);
    end
    for (int m = 0; m < 2; m++) begin
      drive_rand();
      arm(8'h07, m ? 8'h40 : 8'h06, 8'h24, m ? 8'h02 : 8'h01);
      check({2'h0, lv_en}, 8'h3F);
      check(pump, 8'(model[lof_pkg::PUMP_CFG_ADDR]));
      rd(m ? lof_pkg::LV_SHORT_FLAGS_ADDR : lof_pkg::LV_OPEN_FLAGS_ADDR,
         {2'h0, m ? lv_short : lv_head});
      wr(lof_pkg::BANK_ENABLE_ADDR, 8'h04);
      check({2'h0, lv_en}, 8'h07);
      wr(lof_pkg::BANK_ENABLE_ADDR, 8'h00);
    end
    // own-bank mapping: sink 2 on bank D, sink 6 on bank H
    wr(lof_pkg::LV_SINK_CFG_ADDR, 8'h3F);
    wr(lof_pkg::BANK_ENABLE_ADDR, 8'h88);
    check({2'h0, lv_en}, 8'h22);
    wr(lof_pkg::BANK_ENABLE_ADDR, 8'h00);
    // sticky flags must drop on a fresh enable write
    wr(lof_pkg::FAULT_ENABLE_ADDR, 8'h03);
    rd(lof_pkg::LV_SHORT_FLAGS_ADDR, 8'h00);
    rd(lof_pkg::PUMP_CFG_ADDR, 8'(model[lof_pkg::PUMP_CFG_ADDR]));
    rd(8'hC0, 8'h00);
    print_verdict();
  end
endmodule
